// ==== rtl/acs_top.sv ====
// wishbone-controlled sequencer for a 12-bit successive-approximation adc
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_top
(
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     irq_o,
    input  wire logic                rc_tick_i,
    input  wire acs_pkg::acs_result_t adc_data_i,
    output logic                     adc_sample_o,
    output logic                     adc_tad_o,
    output logic      [3:0]          adc_ch_o,
    output logic      [7:0]          adc_cfg_o
);
    import acs_pkg::*;

    acs_state_e  state_q;
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  ctrl_c_q;
    logic        go_q;
    logic        flag_q;
    logic [7:0]  mask_q;
    acs_result_t res_q;
    acs_clksel_t clk_sel_q;
    logic [7:0]  acq_len_q;
    logic [7:0]  step_q;
    logic [2:0]  dly_q;
    logic [15:0] conv_cyc_q;

    logic        req;
    logic        wr;
    logic [7:0]  wdat;
    logic [7:0]  rd_mux;
    logic        wr_ctrl_a;
    logic        start_req;
    logic        conv_done;
    logic        tad_tick;
    logic        tad_run;
    logic        mod_on;
    acs_clksel_t clk_sel;
    acs_acqsel_t acq_sel;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the request, write on the ack edge
    assign req  = wb_cyc_i && wb_stb_i;
    assign wr   = req && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req && !wb_ack_o;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_ack_o)
            wb_dat_o <= {24'h00_0000, rd_mux};
    end

    // left or right justified result split over the byte pair
    always_comb
    begin
        if (ctrl_c_q[`ACS_C_FMT])
        begin
            res_hi = {4'h0, res_q[11:8]};
            res_lo = res_q[7:0];
        end
        else
        begin
            res_hi = res_q[11:4];
            res_lo = {res_q[3:0], 4'h0};
        end
    end

    always_comb
    begin
        if (wb_adr_i == `ACS_OFF_CTRL_A)
            rd_mux = {ctrl_a_q[7:2], go_q, ctrl_a_q[0]};
        else if (wb_adr_i == `ACS_OFF_CTRL_B)
            rd_mux = ctrl_b_q;
        else if (wb_adr_i == `ACS_OFF_CTRL_C)
            rd_mux = ctrl_c_q;
        else if (wb_adr_i == `ACS_OFF_RES_HI)
            rd_mux = res_hi;
        else if (wb_adr_i == `ACS_OFF_RES_LO)
            rd_mux = res_lo;
        else if (wb_adr_i == `ACS_OFF_IRQ_STAT)
            rd_mux = {7'h00, flag_q};
        else if (wb_adr_i == `ACS_OFF_IRQ_MASK)
            rd_mux = mask_q;
        else
            rd_mux = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    assign wr_ctrl_a = wr && wb_adr_i == `ACS_OFF_CTRL_A;
    assign mod_on    = ctrl_a_q[`ACS_A_ON];
    assign clk_sel   = ctrl_c_q[`ACS_C_CLK_LSB +: 3];
    assign acq_sel   = ctrl_c_q[`ACS_C_ACQ_LSB +: 3];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_a_q <= `ACS_RST_CTRL;
            ctrl_b_q <= `ACS_RST_CTRL;
            ctrl_c_q <= `ACS_RST_CTRL;
            mask_q   <= `ACS_RST_MASK;
        end
        else if (wr)
        begin
            if (wb_adr_i == `ACS_OFF_CTRL_A)
                ctrl_a_q <= wdat;
            else if (wb_adr_i == `ACS_OFF_CTRL_B)
                ctrl_b_q <= wdat;
            else if (wb_adr_i == `ACS_OFF_CTRL_C)
                ctrl_c_q <= wdat & `ACS_C_WMASK;
            else if (wb_adr_i == `ACS_OFF_IRQ_MASK)
                mask_q <= {6'h00, wdat[1:0]};
        end
    end

    // a go written without the on bit set in the same write, or while already busy, is dropped
    assign start_req = wr_ctrl_a && wdat[`ACS_A_GO] && wdat[`ACS_A_ON]
                       && state_q == ST_IDLE;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            go_q <= 1'b0;
        else if (start_req)
            go_q <= 1'b1;
        else if (conv_done || (state_q != ST_IDLE && !mod_on))
            go_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // bit clock
    assign tad_run = state_q == ST_ACQ || state_q == ST_CONV;

    acs_tad_gen u_tad_gen
    (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .run      (tad_run),
        .clk_sel  (clk_sel_q),
        .rc_tick  (rc_tick_i),
        .tad_tick (tad_tick)
    );

    assign conv_done = state_q == ST_CONV && mod_on && tad_tick
                       && step_q == `ACS_CONV_TADS - 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // sequencer; go alone shows busy, acquisition and conversion look alike
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q   <= ST_IDLE;
            step_q    <= 8'h00;
            dly_q     <= 3'h0;
            clk_sel_q <= 3'h0;
            acq_len_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start_req)
                    begin
                        step_q    <= 8'h00;
                        dly_q     <= 3'h0;
                        clk_sel_q <= clk_sel;
                        acq_len_q <= 8'(acq_sel * `ACS_ACQ_STEP);
                        if (acq_sel != 3'h0)
                            state_q <= ST_ACQ;
                        else if (acs_is_rc(clk_sel))
                            state_q <= ST_DELAY;
                        else
                            state_q <= ST_CONV;
                    end
                ST_DELAY:
                    if (!mod_on)
                        state_q <= ST_IDLE;
                    else if (dly_q == 3'(`ACS_INSTR_OSC - 1))
                        state_q <= ST_CONV;
                    else
                        dly_q <= dly_q + 3'h1;
                ST_ACQ:
                    if (!mod_on)
                        state_q <= ST_IDLE;
                    else if (tad_tick)
                    begin
                        if (step_q == acq_len_q - 8'h01)
                        begin
                            step_q  <= 8'h00;
                            state_q <= ST_CONV;
                        end
                        else
                            step_q <= step_q + 8'h01;
                    end
                ST_CONV:
                    if (!mod_on)
                        state_q <= ST_IDLE;
                    else if (conv_done)
                        state_q <= ST_IDLE;
                    else if (tad_tick)
                        step_q <= step_q + 8'h01;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog side: sampling runs in every state except conversion
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            adc_sample_o <= 1'b1;
            adc_tad_o    <= 1'b0;
            adc_ch_o     <= 4'h0;
            adc_cfg_o    <= 8'h00;
        end
        else
        begin
            adc_sample_o <= !(state_q == ST_CONV && !conv_done
                              && mod_on)
                            && !(start_req && acq_sel == 3'h0
                                 && !acs_is_rc(clk_sel))
                            && !(state_q == ST_DELAY && mod_on
                                 && dly_q == 3'(`ACS_INSTR_OSC - 1))
                            && !(state_q == ST_ACQ && mod_on && tad_tick
                                 && step_q == acq_len_q - 8'h01);
            adc_tad_o    <= tad_tick && state_q == ST_CONV;
            adc_ch_o     <= ctrl_a_q[`ACS_A_CH_LSB +: 4];
            adc_cfg_o    <= ctrl_b_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            res_q <= 12'h000;
        else if (conv_done)
            res_q <= adc_data_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: a completion in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            flag_q <= 1'b0;
        else
            flag_q <= (flag_q && !(wr && wdat[0]
                       && wb_adr_i == `ACS_OFF_IRQ_STAT))
                      || conv_done;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_o <= 1'b0;
        else
            irq_o <= flag_q && mask_q[`ACS_M_CONV_EN]
                     && mask_q[`ACS_M_GLOB_EN];
    end

    ////////////////////////////////////////////////////////////////////////
    // helper: cycles since the conversion began, counted from the last
    // acquisition tick when acquisition ran
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            conv_cyc_q <= 16'h0000;
        else if (state_q == ST_CONV)
            conv_cyc_q <= conv_cyc_q + 16'h0001;
        else if (state_q == ST_ACQ)
            conv_cyc_q <= 16'h0001;
        else
            conv_cyc_q <= 16'h0000;
    end

    default clocking acs_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_start_go: assert property (
        start_req |=> go_q && state_q != ST_IDLE)
        else $error("go did not start a conversion");

    a_zero_acq: assert property (
        start_req && acq_sel == 3'h0 && !acs_is_rc(clk_sel)
        |=> state_q == ST_CONV && !adc_sample_o)
        else $error("zero acquisition did not convert at once");

    a_acq_first: assert property (
        start_req && acq_sel != 3'h0
        |=> (state_q == ST_ACQ && adc_sample_o)[*4])
        else $error("programmed acquisition was skipped");

    a_done_flags: assert property (
        conv_done |=> !go_q && flag_q && adc_sample_o
                      && state_q == ST_IDLE)
        else $error("completion effects missing");

    a_go_busy: assert property (
        state_q != ST_IDLE |-> go_q)
        else $error("go dropped while busy");

    a_conv_tads: assert property (
        conv_done && !acs_is_rc(clk_sel_q)
        |-> conv_cyc_q == 16'(`ACS_CONV_TADS)
                          * 16'(acs_tad_div(clk_sel_q)))
        else $error("conversion not eleven bit periods");

    a_irq_level: assert property (
        flag_q && mask_q[`ACS_M_CONV_EN] && mask_q[`ACS_M_GLOB_EN]
        ##1 flag_q |-> irq_o)
        else $error("interrupt not raised for set flag");

    a_result_cap: assert property (
        conv_done |=> res_q == $past(adc_data_i))
        else $error("result not captured at completion");

    a_sleep_delay: assert property (
        start_req && acq_sel == 3'h0 && acs_is_rc(clk_sel)
        |=> (state_q != ST_CONV)[*4])
        else $error("rc start not delayed one instruction");
endmodule

// ==== rtl/acs_consts.svh ====
// register offsets, field positions, reset values and counts of the sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_OFF_CTRL_A   8'h00
`define ACS_OFF_CTRL_B   8'h04
`define ACS_OFF_CTRL_C   8'h08
`define ACS_OFF_RES_HI   8'h0c
`define ACS_OFF_RES_LO   8'h10
`define ACS_OFF_IRQ_STAT 8'h14
`define ACS_OFF_IRQ_MASK 8'h18

`define ACS_A_ON         0
`define ACS_A_GO         1
`define ACS_A_CH_LSB     2
`define ACS_C_CLK_LSB    0
`define ACS_C_ACQ_LSB    3
`define ACS_C_FMT        7
`define ACS_C_WMASK      8'hbf
`define ACS_M_CONV_EN    0
`define ACS_M_GLOB_EN    1

`define ACS_RST_CTRL     8'h00
`define ACS_RST_MASK     8'h00

`define ACS_DIV_2        7'h02
`define ACS_DIV_4        7'h04
`define ACS_DIV_8        7'h08
`define ACS_DIV_16       7'h10
`define ACS_DIV_32       7'h20
`define ACS_DIV_64       7'h40
`define ACS_DIV_RC       7'h00

`define ACS_CONV_TADS    8'h0b
`define ACS_INSTR_OSC    4
`define ACS_ACQ_STEP     2

`endif

// ==== rtl/acs_pkg.sv ====
// types and shared clock-select decode of the conversion sequencer
`include "acs_consts.svh"
package acs_pkg;
    typedef logic [2:0]  acs_clksel_t;
    typedef logic [2:0]  acs_acqsel_t;
    typedef logic [11:0] acs_result_t;
    typedef logic [6:0]  acs_div_t;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_ACQ   = 4'b0100,
        ST_CONV  = 4'b1000
    } acs_state_e;

    // any x11 code selects the internal rc source
    function automatic logic acs_is_rc(input acs_clksel_t sel);
        return sel[1:0] == 2'b11;
    endfunction

    // oscillator periods per bit; zero means rc source
    function automatic acs_div_t acs_tad_div(input acs_clksel_t sel);
        acs_div_t div;
        div = `ACS_DIV_RC;
        case (sel)
            3'b000:  div = `ACS_DIV_2;
            3'b100:  div = `ACS_DIV_4;
            3'b001:  div = `ACS_DIV_8;
            3'b101:  div = `ACS_DIV_16;
            3'b010:  div = `ACS_DIV_32;
            3'b110:  div = `ACS_DIV_64;
            default: div = `ACS_DIV_RC;
        endcase
        return div;
    endfunction
endpackage

// ==== rtl/acs_tad_gen.sv ====
// per-bit conversion clock: oscillator divider or internal rc tick
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_tad_gen
(
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                run,
    input  wire acs_pkg::acs_clksel_t clk_sel,
    input  wire logic                rc_tick,
    output logic                     tad_tick
);
    import acs_pkg::*;

    acs_div_t cnt_q;
    acs_div_t period;
    acs_div_t gap_q;

    assign period = acs_tad_div(clk_sel);

    ////////////////////////////////////////////////////////////////////////
    // counter restarts whenever run drops, so with a divider source the first tick is a full period; rc ticks pass straight through
    always_ff @(posedge ref_clk)
    begin
        if (srst || !run)
        begin
            cnt_q    <= 7'h00;
            tad_tick <= 1'b0;
        end
        else if (acs_is_rc(clk_sel))
        begin
            cnt_q    <= 7'h00;
            tad_tick <= rc_tick;
        end
        else if (cnt_q == period - 7'h01)
        begin
            cnt_q    <= 7'h00;
            tad_tick <= 1'b1;
        end
        else
        begin
            cnt_q    <= cnt_q + 7'h01;
            tad_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk)
    begin
        if (srst || !run)
            gap_q <= 7'h00;
        else if (tad_tick)
            gap_q <= 7'h01;
        else
            gap_q <= gap_q + 7'h01;
    end

    a_tad_spacing: assert property (
        @(posedge ref_clk) disable iff (srst)
        (run && tad_tick && !acs_is_rc(clk_sel)) |-> gap_q == period)
        else $error("bit period does not match clock select");
endmodule

// ==== verification/acs_core_model.sv ====
// behavioural analog multiplexer and sampling core facing the sequencer
`timescale 1ns/1ns
module acs_core_model
import acs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       adc_sample_o,
    input  wire logic       adc_tad_o,
    input  wire logic [3:0] adc_ch_o,
    output acs_result_t     adc_data_i,
    output logic [7:0]      tad_cnt,
    output logic [7:0]      tad_gap
);
    logic [7:0] gap_run;
    logic       samp_q;

    initial
    begin
        adc_data_i = 12'h000;
        tad_cnt = 8'h00;
        tad_gap = 8'h00;
        gap_run = 8'h00;
        samp_q = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
    begin
        samp_q <= adc_sample_o;
        // junk while sampling, so an early capture shows up as a mismatch
        if (adc_sample_o)
            adc_data_i <= adc_data_i + 12'h3a7;
        else
            adc_data_i <= {adc_ch_o, ~adc_ch_o, adc_ch_o ^ 4'ha};
        if (samp_q && !adc_sample_o)
            tad_cnt <= 8'h00;
        else if (adc_tad_o)
            tad_cnt <= tad_cnt + 8'h01;
        gap_run <= adc_tad_o ? 8'h01 : gap_run + 8'h01;
        if (adc_tad_o)
            tad_gap <= gap_run;
    end
endmodule

// ==== verification/acs_top_tb_top.sv ====
// self-checking bench for the wishbone adc conversion sequencer
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_top_tb_top;
    import acs_pkg::*;
    logic        ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, rc_tick_i;
    logic        wb_ack_o, irq_o, adc_sample_o, adc_tad_o, samp_d;
    logic [7:0]  wb_adr_i, adc_cfg_o, tad_cnt, tad_gap;
    logic [3:0]  wb_sel_i, adc_ch_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd_last, rng_q;
    acs_result_t adc_data_i;
    logic [31:0] rd_q[$];
    int          err_total, n_checks, cyc_n, t_fall, t_ack, rc_div, i;

    acs_top uut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rc_tick_i(rc_tick_i),
        .adc_data_i(adc_data_i), .adc_sample_o(adc_sample_o),
        .adc_tad_o(adc_tad_o), .adc_ch_o(adc_ch_o), .adc_cfg_o(adc_cfg_o));
    acs_core_model core (.ref_clk(ref_clk), .adc_sample_o(adc_sample_o),
        .adc_tad_o(adc_tad_o), .adc_ch_o(adc_ch_o),
        .adc_data_i(adc_data_i), .tad_cnt(tad_cnt), .tad_gap(tad_gap));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic timeout();
        err_total++;
        $display("FAIL timeout expected answer seen none");
        final_report();
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // every signal moves just after an edge and holds until ack is seen
    task automatic wb_xfer(input logic w, input logic [7:0] a,
                           input logic [31:0] d);
        int k;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (k == 20)
            timeout();
        t_ack = cyc_n;
        rd_last = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb_xfer(1'b0, a, 32'h0);
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 1000; k++)
        begin
            wb_xfer(1'b0, `ACS_OFF_CTRL_A, 32'h0);
            if (rd_last[`ACS_A_GO] === 1'b0)
                break;
        end
        if (k == 1000)
            timeout();
    endtask

    task automatic convert(input logic [2:0] cs, aq, input logic fmt,
                           input int n);
        logic [3:0]  ch;
        logic [11:0] r;
        logic [31:0] eh, el;
        int          t0, lo, hi;
        ch = 4'(rnd());
        r = {ch, ~ch, ch ^ 4'ha};
        eh = fmt ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
        el = fmt ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
        lo = 2 * aq * n - (aq != 0 ? n : 0);
        hi = 2 * aq * n + (aq != 0 ? n : 0) + 8;
        wr(`ACS_OFF_CTRL_A, {26'h0, ch, 2'b00});
        wr(`ACS_OFF_CTRL_C, {24'h0, fmt, 1'b0, aq, cs});
        wr(`ACS_OFF_CTRL_A, {26'h0, ch, 2'b01});
        wr(`ACS_OFF_IRQ_STAT, 32'h1);
        wr(`ACS_OFF_CTRL_A, {26'h0, ch, 2'b11});
        t0 = t_ack;
        rd(`ACS_OFF_CTRL_A, {26'h0, ch, 2'b11});
        rd(`ACS_OFF_IRQ_STAT, 32'h0);
        wait_done();
        chk("acq time", (t_fall - t0) inside {[lo:hi]}, 1);
        chk("channel", adc_ch_o, ch);
        chk("tad count", tad_cnt, 8'h0b);
        chk("tad gap", tad_gap, n);
        chk("sampling", adc_sample_o, 1'b1);
        rd(`ACS_OFF_IRQ_STAT, 32'h1);
        rd(`ACS_OFF_RES_HI, eh);
        rd(`ACS_OFF_RES_LO, el);
        repeat (2 * n) @(posedge ref_clk);
        $display("test convert sel %b acq %0d done", cs, aq);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // results are compared in the order they were requested
    always @(posedge ref_clk)
    begin
        cyc_n <= cyc_n + 1;
        if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0)
            chk("read data", wb_dat_o, rd_q.pop_front());
        if (samp_d === 1'b1 && adc_sample_o === 1'b0)
            t_fall = cyc_n;
        samp_d = adc_sample_o;
        rc_div <= (rc_div == 6) ? 0 : rc_div + 1;
        rc_tick_i <= (rc_div == 6);
    end

    initial
    begin
        {srst, wb_cyc_i, wb_stb_i, wb_we_i, rc_tick_i, samp_d} = 6'b100001;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {err_total, n_checks, cyc_n, t_fall, rc_div} = '0;
        rng_q = 32'ha696;
        wb_sel_i = 4'hf;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 32; i += 4)
            rd(i[7:0], 32'h0);
        wr(`ACS_OFF_CTRL_C, 32'hff);
        rd(`ACS_OFF_CTRL_C, 32'hbf);
        wr(8'h1c, 32'h5a);
        rd(8'h1c, 32'h0);
        void'(rnd());
        wr(`ACS_OFF_CTRL_B, {24'h0, rng_q[7:0]});
        // a write with lane 0 off is acked but must leave the register alone
        wb_sel_i <= 4'he;
        wr(`ACS_OFF_CTRL_B, {24'h0, ~rng_q[7:0]});
        wb_sel_i <= 4'hf;
        rd(`ACS_OFF_CTRL_B, {24'h0, rng_q[7:0]});
        chk("cfg", adc_cfg_o, rng_q[7:0]);
        $display("test registers done");
        wr(`ACS_OFF_IRQ_MASK, 32'h3);
        for (i = 0; i < 6; i++)
            convert(i[0] ? 3'(i >> 1) | 3'b100 : 3'(i >> 1), 3'h0, i[0],
                    2 << i);
        convert(3'b001, 3'h3, 1'b1, 8);
        convert(3'b011, 3'h0, 1'b0, 7);
        convert(3'b111, 3'h2, 1'b1, 7);
        convert(3'b110, 3'h7, 1'b0, 64);
        chk("irq", irq_o, 1'b1);
        wr(`ACS_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq", irq_o, 1'b0);
        wr(`ACS_OFF_IRQ_MASK, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk("irq", irq_o, 1'b1);
        wr(`ACS_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq", irq_o, 1'b0);
        $display("test interrupt done");
        // abort in mid-conversion, so that sampling visibly resumes
        wr(`ACS_OFF_CTRL_C, 32'h06);
        wr(`ACS_OFF_CTRL_A, 32'h0e);
        wr(`ACS_OFF_CTRL_A, 32'h0f);
        repeat (100) @(posedge ref_clk);
        chk("converting", adc_sample_o, 1'b0);
        rd(`ACS_OFF_CTRL_A, 32'h0f);
        wr(`ACS_OFF_CTRL_A, 32'h0c);
        repeat (2) @(posedge ref_clk);
        chk("abort", adc_sample_o, 1'b1);
        rd(`ACS_OFF_CTRL_A, 32'h0c);
        rd(`ACS_OFF_IRQ_STAT, 32'h0);
        i = t_fall;
        wr(`ACS_OFF_CTRL_A, 32'h0e);
        repeat (40) @(posedge ref_clk);
        chk("refused go", t_fall, i);
        rd(`ACS_OFF_CTRL_A, 32'h0c);
        $display("test abort and refusal done");
        final_report();
    end
endmodule
